/* rtl/ctm_mode_ctrl.sv */
// The address map and the AXI4-Lite interface to the registers were decided locally.
module ctm_mode_ctrl #(
  parameter int HOLD_CYCLES = ctm_pkg::HOLD_CYCLES,
  parameter int FILTER_CYCLES = ctm_pkg::FILTER_CYCLES,
  parameter int DETECT_CYCLES = ctm_pkg::DETECT_CYCLES
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // host control pins
  input wire logic standby_select_n_in,
  input wire logic mode_select_in,
  input wire logic tx_data_in,
  output logic rx_data_out,
  output logic error_n_out,
  // regulator inhibit pin
  output logic regulator_inhibit_out,
  output logic regulator_inhibit_oe_n_out,
  // analog front end
  input wire logic bus_rx_in,
  input wire logic remote_wake_in,
  input wire logic rouse_pin_in,
  input wire logic core_supply_low_in,
  input wire logic battery_low_in,
  output logic bus_tx_out,
  output logic tx_enable_out,
  output logic rx_enable_out,
  output logic monitor_enable_out,
  // axi4-lite slave
  input wire logic [ctm_pkg::ADDR_W-1:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  input wire logic [ctm_pkg::ADDR_W-1:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in
);

  localparam int TW = ctm_pkg::TIMER_W;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [TW-1:0] merge_bytes(
    input logic [TW-1:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0] wstrb
  );
    logic [TW-1:0] res;
    res = old_val;
    if (wstrb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (wstrb[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  function automatic logic is_low_power(input ctm_pkg::ctm_mode_t m);
    return (m == ctm_pkg::CTM_STANDBY) || (m == ctm_pkg::CTM_GO_SLEEP) ||
      (m == ctm_pkg::CTM_SLEEP);
  endfunction

  // ****************************************************************
  // control input synchronisers
  // ****************************************************************
  // bit 1 standby-select (high = not standby), bit 0 mode-select
  logic [1:0] ctl_meta_q;
  logic [1:0] ctl_sync_q;
  logic [1:0] ctl_prev_q;
  logic ctl_changed;
  logic stb_rise;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_meta_q <= 2'h0;
      ctl_sync_q <= 2'h0;
      ctl_prev_q <= 2'h0;
    end else begin
      ctl_meta_q <= {standby_select_n_in, mode_select_in};
      ctl_sync_q <= ctl_meta_q;
      ctl_prev_q <= ctl_sync_q;
    end
  end

  assign ctl_changed = ctl_sync_q != ctl_prev_q;
  assign stb_rise = ctl_sync_q[1] && !ctl_prev_q[1];

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [TW-1:0] hold_limit_q;
  logic [TW-1:0] filter_limit_q;

  // ****************************************************************
  // timers
  // ****************************************************************
  ctm_pkg::ctm_mode_t mode_q;
  ctm_pkg::ctm_mode_t mode_d;
  logic rouse_q;
  logic hold_done;
  logic filter_done;
  logic detect_done;
  logic detect_prev_q;
  logic rouse_level_q;

  // any control change or rouse restarts the hold count
  ctm_hold_timer #(.WIDTH(TW)) u_hold (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .restart_in((mode_q != ctm_pkg::CTM_GO_SLEEP) || ctl_changed ||
      rouse_q),
    .limit_in(hold_limit_q),
    .done_out(hold_done)
  );

  // rouse pin must hold its new level for the filter time
  ctm_hold_timer #(.WIDTH(TW)) u_filter (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .restart_in(rouse_pin_in == rouse_level_q),
    .limit_in(filter_limit_q),
    .done_out(filter_done)
  );

  ctm_hold_timer #(.WIDTH(TW)) u_detect (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .restart_in(!core_supply_low_in),
    .limit_in(TW'(DETECT_CYCLES)),
    .done_out(detect_done)
  );

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rouse_level_q <= 1'b0;
      detect_prev_q <= 1'b0;
    end else begin
      detect_prev_q <= detect_done;
      if (filter_done) begin
        rouse_level_q <= rouse_pin_in;
      end
    end
  end

  // ****************************************************************
  // internal flags
  // ****************************************************************
  logic core_supply_low_flag_q;
  logic battery_low_flag_q;
  logic pwon_q;
  logic wake_src_q;
  logic core_set;
  logic pwon_set;
  logic local_req;
  logic rouse_set;
  logic enter_normal;

  assign core_set = detect_done && !detect_prev_q;
  assign pwon_set = battery_low_flag_q && !battery_low_in;
  assign local_req = filter_done && (rouse_pin_in != rouse_level_q);
  assign rouse_set = ((local_req || remote_wake_in) && is_low_power(mode_q))
    || pwon_set;
  assign enter_normal = (mode_d == ctm_pkg::CTM_NORMAL) &&
    (mode_q != ctm_pkg::CTM_NORMAL);

  // a new detection beats every clear source
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      core_supply_low_flag_q <= 1'b0;
    end else if (core_set) begin
      core_supply_low_flag_q <= 1'b1;
    end else if (rouse_set || stb_rise || !core_supply_low_in) begin
      core_supply_low_flag_q <= 1'b0;
    end
  end

  // rouse is up at power-on so the host learns of the start
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rouse_q <= 1'b1;
    end else if (core_set) begin
      rouse_q <= 1'b0;
    end else if (rouse_set) begin
      rouse_q <= 1'b1;
    end else if (enter_normal) begin
      rouse_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      battery_low_flag_q <= 1'b0;
    end else begin
      battery_low_flag_q <= battery_low_in;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pwon_q <= 1'b1;
    end else if (pwon_set) begin
      pwon_q <= 1'b1;
    end else if (enter_normal) begin
      pwon_q <= 1'b0;
    end
  end

  // remembers a local request; visible until Normal is left
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wake_src_q <= 1'b0;
    end else if (local_req) begin
      wake_src_q <= 1'b1;
    end else if (mode_q == ctm_pkg::CTM_NORMAL &&
                 mode_d != ctm_pkg::CTM_NORMAL) begin
      wake_src_q <= 1'b0;
    end
  end

  // ****************************************************************
  // mode selection
  // ****************************************************************
  always_comb begin
    mode_d = mode_q;
    if (core_supply_low_flag_q) begin
      mode_d = ctm_pkg::CTM_SLEEP;
    end else if (ctl_sync_q[1] && battery_low_flag_q) begin
      mode_d = ctm_pkg::CTM_STANDBY;
    end else if (ctl_sync_q[1]) begin
      mode_d = ctl_sync_q[0] ? ctm_pkg::CTM_NORMAL :
        ctm_pkg::CTM_LISTEN;
    end else if (rouse_q) begin
      mode_d = ctm_pkg::CTM_STANDBY;
    end else begin
      case (mode_q)
        ctm_pkg::CTM_SLEEP: begin
          mode_d = ctm_pkg::CTM_SLEEP;
        end
        ctm_pkg::CTM_GO_SLEEP: begin
          if (!ctl_sync_q[0]) begin
            mode_d = ctm_pkg::CTM_STANDBY;
          end else if (hold_done) begin
            mode_d = ctm_pkg::CTM_SLEEP;
          end else begin
            mode_d = ctm_pkg::CTM_GO_SLEEP;
          end
        end
        default: begin
          mode_d = ctl_sync_q[0] ? ctm_pkg::CTM_GO_SLEEP :
            ctm_pkg::CTM_STANDBY;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q <= ctm_pkg::CTM_STANDBY;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  logic supplies_ok;

  assign supplies_ok = !battery_low_flag_q && !core_supply_low_flag_q;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      regulator_inhibit_out <= 1'b1;
      regulator_inhibit_oe_n_out <= 1'b0;
      tx_enable_out <= 1'b0;
      rx_enable_out <= 1'b0;
      monitor_enable_out <= 1'b1;
    end else begin
      regulator_inhibit_out <= 1'b1;
      regulator_inhibit_oe_n_out <= mode_q == ctm_pkg::CTM_SLEEP;
      tx_enable_out <= mode_q == ctm_pkg::CTM_NORMAL;
      rx_enable_out <= !is_low_power(mode_q);
      monitor_enable_out <= is_low_power(mode_q);
    end
  end

  // recessive is high; bus stays released outside Normal
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      bus_tx_out <= 1'b1;
      rx_data_out <= 1'b1;
    end else begin
      bus_tx_out <= (mode_q == ctm_pkg::CTM_NORMAL) ? tx_data_in : 1'b1;
      if (!is_low_power(mode_q)) begin
        rx_data_out <= bus_rx_in;
      end else begin
        rx_data_out <= !(rouse_q && supplies_ok);
      end
    end
  end

  // low means the selected flag is set
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      error_n_out <= 1'b1;
    end else begin
      case (mode_q)
        ctm_pkg::CTM_NORMAL: error_n_out <= !wake_src_q;
        ctm_pkg::CTM_LISTEN: error_n_out <= !pwon_q;
        default: error_n_out <= !(rouse_q && supplies_ok);
      endcase
    end
  end

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  logic aw_held_q;
  logic w_held_q;
  logic [ctm_pkg::ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [31:0] status_word;

  assign axi_awready_out = !aw_held_q && !axi_bvalid_out;
  assign axi_wready_out = !w_held_q && !axi_bvalid_out;
  assign axi_arready_out = !axi_rvalid_out;

  // address and data may come in either order; both are held
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else if (aw_held_q && w_held_q) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
    end else begin
      if (axi_awvalid_in && axi_awready_out) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= axi_awaddr_in;
      end
      if (axi_wvalid_in && axi_wready_out) begin
        w_held_q <= 1'b1;
        w_data_q <= axi_wdata_in;
        w_strb_q <= axi_wstrb_in;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      hold_limit_q <= TW'(HOLD_CYCLES);
      filter_limit_q <= TW'(FILTER_CYCLES);
      axi_bvalid_out <= 1'b0;
      axi_bresp_out <= ctm_pkg::RESP_OKAY;
    end else if (aw_held_q && w_held_q) begin
      axi_bvalid_out <= 1'b1;
      axi_bresp_out <= ctm_pkg::RESP_OKAY;
      case (aw_addr_q)
        ctm_pkg::ADDR_HOLD: begin
          hold_limit_q <= merge_bytes(hold_limit_q, w_data_q, w_strb_q);
        end
        ctm_pkg::ADDR_FILTER: begin
          filter_limit_q <= merge_bytes(filter_limit_q, w_data_q,
            w_strb_q);
        end
        ctm_pkg::ADDR_STATUS: begin
          axi_bresp_out <= ctm_pkg::RESP_OKAY;
        end
        default: begin
          axi_bresp_out <= ctm_pkg::RESP_SLVERR;
        end
      endcase
    end else if (axi_bvalid_out && axi_bready_in) begin
      axi_bvalid_out <= 1'b0;
    end
  end

  always_comb begin
    status_word = 32'h0;
    status_word[ctm_pkg::ST_MODE_LSB +: 5] = mode_q;
    status_word[ctm_pkg::ST_CORE_LOW] = core_supply_low_flag_q;
    status_word[ctm_pkg::ST_BATT_LOW] = battery_low_flag_q;
    status_word[ctm_pkg::ST_ROUSE] = rouse_q;
    status_word[ctm_pkg::ST_PWON] = pwon_q;
    status_word[ctm_pkg::ST_WAKE_SRC] = wake_src_q;
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      axi_rvalid_out <= 1'b0;
      axi_rdata_out <= 32'h0;
      axi_rresp_out <= ctm_pkg::RESP_OKAY;
    end else if (axi_arvalid_in && axi_arready_out) begin
      axi_rvalid_out <= 1'b1;
      axi_rresp_out <= ctm_pkg::RESP_OKAY;
      case (axi_araddr_in)
        ctm_pkg::ADDR_STATUS: axi_rdata_out <= status_word;
        ctm_pkg::ADDR_HOLD: axi_rdata_out <= 32'(hold_limit_q);
        ctm_pkg::ADDR_FILTER: axi_rdata_out <= 32'(filter_limit_q);
        default: begin
          axi_rdata_out <= 32'h0;
          axi_rresp_out <= ctm_pkg::RESP_SLVERR;
        end
      endcase
    end else if (axi_rvalid_out && axi_rready_in) begin
      axi_rvalid_out <= 1'b0;
    end
  end

endmodule

/* rtl/ctm_pkg.sv */
package ctm_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int NS_PER_US = 1000;
  // minimum go-to-sleep hold time, local wake filter, undervoltage
  // detection time; all are least times, so they round up
  localparam int HOLD_TIME_US = 50;
  localparam int FILTER_TIME_US = 50;
  localparam int DETECT_TIME_US = 20;
  localparam int HOLD_CYCLES =
    (HOLD_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILTER_CYCLES =
    (FILTER_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DETECT_CYCLES =
    (DETECT_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_HOLD = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_FILTER = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // status field positions
  localparam int ST_MODE_LSB = 0;
  localparam int ST_CORE_LOW = 5;
  localparam int ST_BATT_LOW = 6;
  localparam int ST_ROUSE = 7;
  localparam int ST_PWON = 8;
  localparam int ST_WAKE_SRC = 9;

  // ****************************************************************
  // operating modes
  // ****************************************************************
  typedef enum logic [4:0] {
    CTM_NORMAL = 5'b00001,
    CTM_LISTEN = 5'b00010,
    CTM_STANDBY = 5'b00100,
    CTM_GO_SLEEP = 5'b01000,
    CTM_SLEEP = 5'b10000
  } ctm_mode_t;

endpackage

/* rtl/ctm_hold_timer.sv */
module ctm_hold_timer #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // control
  input wire logic restart_in,
  input wire logic [WIDTH-1:0] limit_in,
  // result
  output logic done_out
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  // saturates at the limit so done stays up until the next restart
  always_comb begin
    if (restart_in) begin
      count_d = '0;
    end else if (count_q < limit_in) begin
      count_d = count_q + WIDTH'(1);
    end else begin
      count_d = count_q;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      count_q <= '0;
      done_out <= 1'b0;
    end else begin
      count_q <= count_d;
      done_out <= !restart_in && (count_d >= limit_in);
    end
  end

endmodule

/* verif/ctm_mode_checker.sv */
module ctm_mode_checker #(
  parameter int HOLD_CYCLES = 8,
  parameter int DETECT_CYCLES = 4
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // inputs watched
  input wire logic standby_select_n_in,
  input wire logic mode_select_in,
  input wire logic core_supply_low_in,
  input wire logic battery_low_in,
  input wire logic rouse_pin_in,
  input wire logic remote_wake_in,
  // outputs watched
  input wire logic error_n_out,
  input wire logic regulator_inhibit_out,
  input wire logic regulator_inhibit_oe_n_out,
  input wire logic bus_tx_out,
  input wire logic tx_enable_out,
  input wire logic rx_enable_out,
  input wire logic monitor_enable_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // ****************************************************************
  // cycles since any control or flag input last moved
  // ****************************************************************
  logic [5:0] cur;
  logic [5:0] prev_q;
  logic [7:0] sc_q;
  assign cur = {standby_select_n_in, mode_select_in, core_supply_low_in,
    battery_low_in, rouse_pin_in, remote_wake_in};
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      prev_q <= 6'h00;
      sc_q <= 8'h00;
    end else begin
      prev_q <= cur;
      if (cur != prev_q) sc_q <= 8'h00;
      else if (sc_q != 8'hFF) sc_q <= sc_q + 8'h01;
    end
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_normal;
    sc_q == 8'h06 && standby_select_n_in && mode_select_in &&
      !core_supply_low_in && !battery_low_in |->
      tx_enable_out && rx_enable_out && !regulator_inhibit_oe_n_out;
  endproperty
  a_normal: assert property (p_normal)
    else $error("normal mode outputs wrong");
  property p_listen;
    sc_q == 8'h06 && standby_select_n_in && !mode_select_in &&
      !core_supply_low_in && !battery_low_in |->
      !tx_enable_out && rx_enable_out && !regulator_inhibit_oe_n_out;
  endproperty
  a_listen: assert property (p_listen)
    else $error("listen-only outputs wrong");
  property p_batt;
    sc_q == 8'h06 && standby_select_n_in && battery_low_in &&
      !core_supply_low_in |->
      monitor_enable_out && !tx_enable_out && !regulator_inhibit_oe_n_out;
  endproperty
  a_batt: assert property (p_batt)
    else $error("battery low did not give standby");
  property p_sleep;
    sc_q == 8'(HOLD_CYCLES + 8) && !standby_select_n_in && mode_select_in &&
      error_n_out |-> regulator_inhibit_oe_n_out;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep not reached after hold");
  property p_core;
    sc_q == 8'(DETECT_CYCLES + 8) && core_supply_low_in |->
      regulator_inhibit_oe_n_out && !tx_enable_out;
  endproperty
  a_core: assert property (p_core)
    else $error("core supply low did not force sleep");
  property p_rise;
    $rose(regulator_inhibit_oe_n_out) |->
      sc_q >= (core_supply_low_in ? DETECT_CYCLES : HOLD_CYCLES);
  endproperty
  a_rise: assert property (p_rise)
    else $error("inhibit released too early");
  property p_mon;
    monitor_enable_out |-> !tx_enable_out && !rx_enable_out;
  endproperty
  a_mon: assert property (p_mon)
    else $error("monitor on with data path on");
  property p_inh;
    regulator_inhibit_out;
  endproperty
  a_inh: assert property (p_inh)
    else $error("inhibit drive level not high");
  property p_txrec;
    !tx_enable_out && !$past(tx_enable_out) |-> bus_tx_out;
  endproperty
  a_txrec: assert property (p_txrec)
    else $error("bus driven with transmitter off");
endmodule

bind ctm_mode_ctrl ctm_mode_checker #(
  .HOLD_CYCLES(HOLD_CYCLES),
  .DETECT_CYCLES(DETECT_CYCLES)
) ctm_mode_checker_i (.clock_in, .rst_in, .standby_select_n_in,
  .mode_select_in, .core_supply_low_in, .battery_low_in, .rouse_pin_in,
  .remote_wake_in, .error_n_out, .regulator_inhibit_out,
  .regulator_inhibit_oe_n_out, .bus_tx_out, .tx_enable_out,
  .rx_enable_out, .monitor_enable_out);

/* verif/ctm_host_model.sv */
module ctm_host_model (
  // clock
  input wire logic clock_in,
  // requests from the bench
  input wire logic stb_req_in,
  input wire logic mode_req_in,
  input wire logic tx_req_in,
  // control pins
  output logic standby_select_n_out = 1'h1,
  output logic mode_select_out = 1'h1,
  output logic tx_data_out = 1'h1
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins move just after an edge and then hold steady
  always @(posedge clock_in) begin
    standby_select_n_out <= stb_req_in;
    mode_select_out <= mode_req_in;
    tx_data_out <= tx_req_in;
  end
endmodule

/* verif/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HOLD = 8;
  localparam int DET = 4;
  logic clock_in = 1'h0;
  logic rst_in = 1'h1;
  logic stb_req = 1'h1, mode_req = 1'h1, tx_req = 1'h1;
  logic standby_select_n_in, mode_select_in, tx_data_in;
  logic bus_rx_in = 1'h1, remote_wake_in = 1'h0, rouse_pin_in = 1'h0;
  logic core_supply_low_in = 1'h0, battery_low_in = 1'h0;
  logic rx_data_out, error_n_out, regulator_inhibit_out;
  logic regulator_inhibit_oe_n_out, bus_tx_out, tx_enable_out;
  logic rx_enable_out, monitor_enable_out;
  logic [7:0] axi_awaddr_in = 8'h00, axi_araddr_in = 8'h00;
  logic axi_awvalid_in = 1'h0, axi_wvalid_in = 1'h0, axi_bready_in = 1'h0;
  logic axi_arvalid_in = 1'h0, axi_rready_in = 1'h0;
  logic [31:0] axi_wdata_in = 32'h0;
  logic [3:0] axi_wstrb_in = 4'hF;
  logic axi_awready_out, axi_wready_out, axi_bvalid_out;
  logic axi_arready_out, axi_rvalid_out;
  logic [1:0] axi_bresp_out, axi_rresp_out, r;
  logic [31:0] axi_rdata_out, v;
  int err_total = 0, n_compared = 0, cyc = 0;
  string cur_t;
  always #50 clock_in = ~clock_in;
  ctm_host_model ctm_host_model_i (.clock_in, .stb_req_in(stb_req),
    .mode_req_in(mode_req), .tx_req_in(tx_req),
    .standby_select_n_out(standby_select_n_in),
    .mode_select_out(mode_select_in), .tx_data_out(tx_data_in));
  ctm_mode_ctrl #(.HOLD_CYCLES(HOLD), .FILTER_CYCLES(4),
    .DETECT_CYCLES(DET)) ctm_mode_ctrl_i (.clock_in, .rst_in,
    .standby_select_n_in, .mode_select_in, .tx_data_in, .rx_data_out,
    .error_n_out, .regulator_inhibit_out, .regulator_inhibit_oe_n_out,
    .bus_rx_in, .remote_wake_in, .rouse_pin_in, .core_supply_low_in,
    .battery_low_in, .bus_tx_out, .tx_enable_out, .rx_enable_out,
    .monitor_enable_out, .axi_awaddr_in, .axi_awvalid_in,
    .axi_awready_out, .axi_wdata_in, .axi_wstrb_in, .axi_wvalid_in,
    .axi_wready_out, .axi_bresp_out, .axi_bvalid_out, .axi_bready_in,
    .axi_araddr_in, .axi_arvalid_in, .axi_arready_out, .axi_rdata_out,
    .axi_rresp_out, .axi_rvalid_out, .axi_rready_in);
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      $display("[FAIL] %0t run timed out", $time);
      summarize();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s: got %h want %h", $time, cur_t, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic pins(input logic s, input logic m);
    @(posedge clock_in);
    stb_req <= s;
    mode_req <= m;
    wt(9);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    axi_awaddr_in <= a;
    axi_wdata_in <= d;
    axi_awvalid_in <= 1'h1;
    axi_wvalid_in <= 1'h1;
    axi_bready_in <= 1'h1;
    do begin
      @(posedge clock_in);
      if (axi_awvalid_in && axi_awready_out) axi_awvalid_in <= 1'h0;
      if (axi_wvalid_in && axi_wready_out) axi_wvalid_in <= 1'h0;
    end while (!axi_bvalid_out);
    r = axi_bresp_out;
    axi_bready_in <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_in);
    axi_araddr_in <= a;
    axi_arvalid_in <= 1'h1;
    axi_rready_in <= 1'h1;
    do begin
      @(posedge clock_in);
      if (axi_arvalid_in && axi_arready_out) axi_arvalid_in <= 1'h0;
    end while (!axi_rvalid_out);
    v = axi_rdata_out;
    r = axi_rresp_out;
    axi_rready_in <= 1'h0;
  endtask
  // status: mode one-hot, then core, battery, rouse and power-on flags
  task automatic st(input logic [4:0] m, input logic [3:0] f);
    rd(ctm_pkg::ADDR_STATUS);
    chk(32'(v[8:0]), 32'({f, m}));
  endtask
  task automatic pinchk(input logic [5:0] exp);
    chk(32'({regulator_inhibit_oe_n_out, monitor_enable_out, tx_enable_out,
      rx_enable_out, error_n_out, rx_data_out}), 32'(exp));
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    cur_t = "reset";
    wt(2);
    pinchk(6'b010011);
    chk(32'(bus_tx_out), 32'h1);
    @(posedge clock_in);
    rst_in <= 1'h0;
    wt(9);
    st(5'h01, 4'h0);
  endtask
  task automatic t_regs;
    cur_t = "registers";
    wr(ctm_pkg::ADDR_HOLD, 32'hFFFF0000 | 32'(HOLD));
    chk(32'(r), 32'(ctm_pkg::RESP_OKAY));
    rd(ctm_pkg::ADDR_HOLD);
    chk(32'(v[15:0]), 32'(HOLD));
    wr(ctm_pkg::ADDR_FILTER, 32'h00000004);
    rd(ctm_pkg::ADDR_FILTER);
    chk(32'(v[15:0]), 32'h4);
    wr(ctm_pkg::ADDR_STATUS, 32'h000000FF);
    chk(32'(r), 32'(ctm_pkg::RESP_OKAY));
    st(5'h01, 4'h0);
    wr(8'h0C, 32'h1);
    chk(32'(r), 32'(ctm_pkg::RESP_SLVERR));
    rd(8'h0C);
    chk({v[29:0], r}, 32'(ctm_pkg::RESP_SLVERR));
  endtask
  task automatic t_normal;
    cur_t = "normal";
    @(posedge clock_in);
    tx_req <= 1'h0;
    bus_rx_in <= 1'h0;
    wt(4);
    chk(32'({bus_tx_out, rx_data_out}), 32'h0);
    @(posedge clock_in);
    tx_req <= 1'h1;
    bus_rx_in <= 1'h1;
  endtask
  task automatic t_listen;
    cur_t = "listen";
    @(posedge clock_in);
    tx_req <= 1'h0;
    pins(1'h1, 1'h0);
    chk(32'(bus_tx_out), 32'h1);
    pinchk(6'b000111);
    st(5'h02, 4'h0);
    tx_req <= 1'h1;
  endtask
  task automatic t_standby;
    cur_t = "standby";
    pins(1'h0, 1'h0);
    pinchk(6'b010011);
    @(posedge clock_in);
    remote_wake_in <= 1'h1;
    @(posedge clock_in);
    remote_wake_in <= 1'h0;
    wt(6);
    pinchk(6'b010000);
    st(5'h04, 4'h4);
  endtask
  task automatic t_core;
    cur_t = "core supply";
    @(posedge clock_in);
    core_supply_low_in <= 1'h1;
    wt(DET + 10);
    chk(32'(regulator_inhibit_oe_n_out), 32'h1);
    st(5'h10, 4'h1);
    @(posedge clock_in);
    core_supply_low_in <= 1'h0;
    wt(9);
    chk(32'(regulator_inhibit_oe_n_out), 32'h1);
    pins(1'h1, 1'h1);
    pinchk(6'b001111);
  endtask
  task automatic t_sleep;
    cur_t = "go to sleep";
    @(posedge clock_in);
    stb_req <= 1'h0;
    wt(7);
    st(5'h08, 4'h0);
    chk(32'(regulator_inhibit_oe_n_out), 32'h0);
    wt(HOLD + 6);
    st(5'h10, 4'h0);
    chk(32'(regulator_inhibit_oe_n_out), 32'h1);
    pins(1'h0, 1'h0);
    st(5'h10, 4'h0);
    pins(1'h1, 1'h1);
    pinchk(6'b001111);
  endtask
  task automatic t_abort;
    cur_t = "abort";
    @(posedge clock_in);
    stb_req <= 1'h0;
    wt(HOLD);
    pins(1'h0, 1'h0);
    wt(HOLD);
    st(5'h04, 4'h0);
    pins(1'h0, 1'h1);
    st(5'h08, 4'h0);
    pins(1'h1, 1'h1);
    @(posedge clock_in);
    stb_req <= 1'h0;
    repeat (3) @(posedge clock_in);
    rouse_pin_in <= 1'h1;
    wt(HOLD + 8);
    pinchk(6'b010000);
    pins(1'h1, 1'h1);
  endtask
  task automatic t_batt;
    cur_t = "battery";
    @(posedge clock_in);
    battery_low_in <= 1'h1;
    wt(8);
    st(5'h04, 4'h2);
    pins(1'h1, 1'h0);
    @(posedge clock_in);
    battery_low_in <= 1'h0;
    wt(8);
    chk(32'(error_n_out), 32'h0);
    st(5'h02, 4'hC);
    pins(1'h1, 1'h1);
    pins(1'h1, 1'h0);
    chk(32'(error_n_out), 32'h1);
  endtask
  initial begin
    t_reset();
    $display("test reset done");
    t_regs();
    $display("test registers done");
    t_normal();
    $display("test normal done");
    t_listen();
    $display("test listen done");
    t_standby();
    $display("test standby done");
    t_core();
    $display("test core supply done");
    t_sleep();
    $display("test go to sleep done");
    t_abort();
    $display("test abort done");
    t_batt();
    $display("test battery done");
    summarize();
  end
endmodule
